// ===== src/iarb_regs.vh
/*
 * Register map, field positions, reset values and timing constants of the
 * I2C arbitration block. Assumes a 32-bit APB slave with word offsets.
 */
`ifndef IARB_REGS_VH
`define IARB_REGS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define IARB_OFF_CTRL1    12'h000
`define IARB_OFF_CTRL2    12'h004
`define IARB_OFF_STATUS   12'h008
`define IARB_OFF_TXBUF    12'h00c
`define IARB_OFF_BAUD     12'h010
`define IARB_OFF_FLAGS    12'h014

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define IARB_C1_EN        0
`define IARB_C1_IE        1
`define IARB_C1_LP        2
`define IARB_C2_START     0
`define IARB_C2_RSTART    1
`define IARB_C2_STOP      2
`define IARB_C2_ACK       4
`define IARB_C2_ACKDT     5
`define IARB_ST_BF        0
`define IARB_ST_START     3
`define IARB_ST_STOP      4
`define IARB_FL_EVENT     0
`define IARB_FL_COLL      1
`define IARB_FL_WCOL      2

// ----------------------------------------------------------------------
// Reset values and widths
// ----------------------------------------------------------------------
`define IARB_BAUD_RST     7'h04
`define IARB_ZERO7        7'h00
`define IARB_ONE7         7'h01
`define IARB_BITS_RST     4'h0
`define IARB_LAST_BIT     4'h8
`define IARB_ACK_BIT      4'h9

`endif

// ===== src/iarb_core.v
/*
 * I2C master bus arbitration and collision handling with an APB register
 * file. Assumes an APB master on core_clk, open-drain SDA/SCL resolved
 * outside, and the SDA/SCL inputs asynchronous to core_clk.
 */
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/10ps
`include "iarb_regs.vh"

// How it works
// - Wake on byte or address in low power
// - Reset disables module, aborts transfer
// - Clear start/stop seen on reset, disable
// - Stop detected raises interrupt when enabled
// - Release SDA for one, mismatch collides
// - Arbitration checked on sent bits, not the ack slot after a byte
// - Transmit collision halts, clears buffer full
// - Sequence collision aborts, clears enables
// - Stop after collision sets event flag
// - New write restarts from first bit
// - Start with low line collides, idles
// - Start loads counter, SCL low collides
// - SDA low early in Start resets counter
// - Second Start count ignores SCL, pulls SCL
// - Repeated Start: release, count, sample SDA
// - Repeated Start SCL fall before timeout collides
// - Both high: drive SDA, count, drive SCL
// - Stop: SDA low, release SCL, count
// - Stop collision on SDA low or SCL low
// - Stop release SDA, flag stop, event
module iarb_core #(
   parameter ADDR_W = 12
) (
   input  wire              core_clk,
   input  wire              rst,
   input  wire              psel,
   input  wire              penable,
   input  wire              pwrite,
   input  wire [ADDR_W-1:0] paddr,
   input  wire [31:0]       pwdata,
   output reg  [31:0]       prdata,
   output wire              pready,
   output wire              pslverr,
   input  wire              sda_in,
   output wire              sda_out,
   output wire              sda_oe,
   input  wire              scl_in,
   output wire              scl_out,
   output wire              scl_oe,
   output wire              irq,
   output wire              wake
);

   // ----------------------------------------------------------------------
   // States
   // ----------------------------------------------------------------------
   localparam ST_IDLE  = 4'd0;
   localparam ST_S1    = 4'd1;
   localparam ST_S2    = 4'd2;
   localparam ST_R1    = 4'd3;
   localparam ST_R2    = 4'd4;
   localparam ST_R3    = 4'd5;
   localparam ST_R4    = 4'd6;
   localparam ST_P1    = 4'd7;
   localparam ST_P2    = 4'd8;
   localparam ST_P3    = 4'd9;
   localparam ST_P4    = 4'd10;
   localparam ST_TLOW  = 4'd11;
   localparam ST_THIGH = 4'd12;
   localparam ST_AK1   = 4'd13;
   localparam ST_AK2   = 4'd14;

   // ----------------------------------------------------------------------
   // Line synchronisers
   // ----------------------------------------------------------------------
   reg [1:0] sda_sync_reg;
   reg [1:0] scl_sync_reg;
   reg       sda_prev_reg;
   reg       scl_prev_reg;
   wire      sda = sda_sync_reg[1];
   wire      scl = scl_sync_reg[1];

   always @(posedge core_clk) begin
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_prev_reg <= sda;
      scl_prev_reg <= scl;
   end

   // Bus conditions seen by any master, including ourselves
   wire bus_start = scl && scl_prev_reg && sda_prev_reg && !sda;
   wire bus_stop  = scl && scl_prev_reg && !sda_prev_reg && sda;

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   reg        en_reg, ie_reg, lp_reg;
   reg        start_req_reg, rstart_req_reg, stop_request_bit_reg;
   reg        ack_req_reg, ackdt_reg;
   reg [6:0]  baud_reload_field_reg;
   reg [7:0]  transmit_buffer_reg;
   reg        buffer_full_flag_reg;
   reg        start_seen_bit_reg, stop_seen_bit_reg;
   reg        serial_event_flag_reg, bus_collision_flag_reg, wcol_reg;
   reg [3:0]  state_reg;
   reg [6:0]  baud_counter_reg;
   reg [7:0]  shift_reg;
   reg [3:0]  bit_cnt_reg;
   reg        sda_drv_reg, scl_drv_reg;
   reg        was_coll_reg;

   wire wr  = psel && penable && pwrite;
   wire rd  = psel && !pwrite;
   wire busy = (state_reg != ST_IDLE);
   wire tick = (baud_counter_reg == `IARB_ZERO7);

   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign sda_out = 1'b0;
   assign scl_out = 1'b0;
   assign sda_oe  = sda_drv_reg;
   assign scl_oe  = scl_drv_reg;
   assign irq  = ie_reg && (serial_event_flag_reg || bus_collision_flag_reg);
   assign wake = lp_reg && irq;

   // ----------------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------------
   // Registered at the setup edge, so read data stands through the access phase
   always @(posedge core_clk) begin
      prdata <= 32'h0000_0000;
      if (rd) begin
         case (paddr)
            `IARB_OFF_CTRL1:  prdata <= {29'h0, lp_reg, ie_reg, en_reg};
            `IARB_OFF_CTRL2:  prdata <= {26'h0, ackdt_reg, ack_req_reg, 1'b0,
                                         stop_request_bit_reg, rstart_req_reg,
                                         start_req_reg};
            `IARB_OFF_STATUS: prdata <= {27'h0, stop_seen_bit_reg, start_seen_bit_reg,
                                         2'b00, buffer_full_flag_reg};
            `IARB_OFF_TXBUF:  prdata <= {24'h0, transmit_buffer_reg};
            `IARB_OFF_BAUD:   prdata <= {25'h0, baud_reload_field_reg};
            `IARB_OFF_FLAGS:  prdata <= {29'h0, wcol_reg, bus_collision_flag_reg,
                                         serial_event_flag_reg};
            default:          prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Control and sequencer
   // ----------------------------------------------------------------------
   reg coll;

   always @* begin
      coll     = 1'b0;
      case (state_reg)
         ST_S1:    coll = sda && !scl;
         ST_R3:    coll = scl && !sda;
         ST_R4:    coll = !scl && sda;
         ST_P3:    coll = !scl;
         ST_P4:    coll = tick && !sda;
         ST_THIGH: coll = scl && !sda_drv_reg && !sda && bit_cnt_reg != `IARB_ACK_BIT - 4'h1;
         ST_AK2:   coll = scl && !sda_drv_reg && !sda;
         default:  coll = 1'b0;
      endcase
   end

   always @(posedge core_clk) begin
      if (rst || !en_reg) begin
         state_reg            <= ST_IDLE;
         start_seen_bit_reg   <= 1'b0;
         stop_seen_bit_reg    <= 1'b0;
         start_req_reg        <= 1'b0;
         rstart_req_reg       <= 1'b0;
         stop_request_bit_reg <= 1'b0;
         ack_req_reg          <= 1'b0;
         buffer_full_flag_reg <= 1'b0;
         sda_drv_reg          <= 1'b0;
         scl_drv_reg          <= 1'b0;
         baud_counter_reg     <= `IARB_ZERO7;
         bit_cnt_reg          <= `IARB_BITS_RST;
         shift_reg            <= 8'h00;
         was_coll_reg         <= 1'b0;
      end else begin
         if (baud_counter_reg != `IARB_ZERO7)
            baud_counter_reg <= baud_counter_reg - `IARB_ONE7;
         if (bus_start) begin
            start_seen_bit_reg <= 1'b1;
            stop_seen_bit_reg  <= 1'b0;
         end
         if (bus_stop) begin
            stop_seen_bit_reg  <= 1'b1;
            start_seen_bit_reg <= 1'b0;
         end
         // Sequence requests only accepted while idle; no queueing
         if (wr && paddr == `IARB_OFF_CTRL2 && !busy) begin
            start_req_reg        <= pwdata[`IARB_C2_START];
            rstart_req_reg       <= pwdata[`IARB_C2_RSTART];
            stop_request_bit_reg <= pwdata[`IARB_C2_STOP];
            ack_req_reg          <= pwdata[`IARB_C2_ACK];
         end
         if (wr && paddr == `IARB_OFF_TXBUF && !busy) begin
            buffer_full_flag_reg <= 1'b1;
            shift_reg            <= pwdata[7:0];
            bit_cnt_reg          <= `IARB_BITS_RST;
         end
         if (coll) begin
            state_reg            <= ST_IDLE;
            sda_drv_reg          <= 1'b0;
            scl_drv_reg          <= 1'b0;
            buffer_full_flag_reg <= 1'b0;
            start_req_reg        <= 1'b0;
            rstart_req_reg       <= 1'b0;
            stop_request_bit_reg <= 1'b0;
            ack_req_reg          <= 1'b0;
            bit_cnt_reg          <= `IARB_BITS_RST;
            was_coll_reg         <= 1'b1;
         end else begin
            case (state_reg)
               ST_IDLE: begin
                  if (start_req_reg) begin
                     if (!sda || !scl) begin
                        start_req_reg <= 1'b0;
                        was_coll_reg  <= 1'b1;
                     end else begin
                        baud_counter_reg <= baud_reload_field_reg;
                        state_reg        <= ST_S1;
                     end
                  end else if (rstart_req_reg) begin
                     sda_drv_reg      <= 1'b0;
                     baud_counter_reg <= baud_reload_field_reg;
                     state_reg        <= ST_R1;
                  end else if (stop_request_bit_reg) begin
                     sda_drv_reg <= 1'b1;
                     state_reg   <= ST_P1;
                  end else if (ack_req_reg) begin
                     scl_drv_reg      <= 1'b1;
                     sda_drv_reg      <= !ackdt_reg;
                     baud_counter_reg <= baud_reload_field_reg;
                     state_reg        <= ST_AK1;
                  end else if (buffer_full_flag_reg) begin
                     scl_drv_reg      <= 1'b1;
                     sda_drv_reg      <= !shift_reg[7];
                     baud_counter_reg <= baud_reload_field_reg;
                     state_reg        <= ST_TLOW;
                  end
               end
               ST_S1: begin
                  if (!sda) begin
                     sda_drv_reg      <= 1'b1;
                     baud_counter_reg <= baud_reload_field_reg;
                     state_reg        <= ST_S2;
                  end else if (tick) begin
                     sda_drv_reg      <= 1'b1;
                     baud_counter_reg <= baud_reload_field_reg;
                     state_reg        <= ST_S2;
                  end
               end
               ST_S2: if (tick) begin
                  scl_drv_reg   <= 1'b1;
                  start_req_reg <= 1'b0;
                  state_reg     <= ST_IDLE;
               end
               ST_R1: if (tick) begin
                  scl_drv_reg <= 1'b0;
                  state_reg   <= ST_R3;
               end
               ST_R3: if (scl) begin
                  baud_counter_reg <= baud_reload_field_reg;
                  state_reg        <= ST_R4;
               end
               ST_R4: if (!sda || tick) begin
                  sda_drv_reg      <= 1'b1;
                  baud_counter_reg <= baud_reload_field_reg;
                  state_reg        <= ST_R2;
               end
               ST_R2: if (tick) begin
                  scl_drv_reg    <= 1'b1;
                  rstart_req_reg <= 1'b0;
                  state_reg      <= ST_IDLE;
               end
               ST_P1: if (!sda) begin
                  scl_drv_reg <= 1'b0;
                  state_reg   <= ST_P2;
               end
               ST_P2: if (scl) begin
                  baud_counter_reg <= baud_reload_field_reg;
                  state_reg        <= ST_P3;
               end
               ST_P3: if (tick) begin
                  sda_drv_reg      <= 1'b0;
                  baud_counter_reg <= baud_reload_field_reg;
                  state_reg        <= ST_P4;
               end
               ST_P4: if (tick) begin
                  stop_request_bit_reg <= 1'b0;
                  state_reg            <= ST_IDLE;
               end
               ST_TLOW: if (tick) begin
                  scl_drv_reg      <= 1'b0;
                  baud_counter_reg <= baud_reload_field_reg;
                  state_reg        <= ST_THIGH;
               end
               ST_THIGH: if (scl && tick) begin
                  scl_drv_reg      <= 1'b1;
                  baud_counter_reg <= baud_reload_field_reg;
                  if (bit_cnt_reg == `IARB_ACK_BIT - 4'h1) begin
                     bit_cnt_reg <= `IARB_BITS_RST;
                     state_reg   <= ST_IDLE;
                  end else begin
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                     shift_reg   <= {shift_reg[6:0], 1'b1};
                     if (bit_cnt_reg == `IARB_LAST_BIT - 4'h1) begin
                        sda_drv_reg          <= 1'b0;
                        buffer_full_flag_reg <= 1'b0;
                     end else begin
                        sda_drv_reg <= !shift_reg[6];
                     end
                     state_reg <= ST_TLOW;
                  end
               end
               ST_AK1: if (tick) begin
                  scl_drv_reg      <= 1'b0;
                  baud_counter_reg <= baud_reload_field_reg;
                  state_reg        <= ST_AK2;
               end
               ST_AK2: if (scl && tick) begin
                  scl_drv_reg <= 1'b1;
                  ack_req_reg <= 1'b0;
                  state_reg   <= ST_IDLE;
               end
               default: state_reg <= ST_IDLE;
            endcase
         end
      end
   end

   // Completion events for the event flag

   wire done_evt = busy && !coll &&
                   ((state_reg == ST_S2 && tick) || (state_reg == ST_R2 && tick) ||
                    (state_reg == ST_P4 && tick) || (state_reg == ST_AK2 && scl && tick) ||
                    (state_reg == ST_THIGH && scl && tick &&
                     bit_cnt_reg == `IARB_ACK_BIT - 4'h1));
   wire start_abort = !busy && start_req_reg && (!sda || !scl);
   wire txbuf_wr    = wr && paddr == `IARB_OFF_TXBUF;
   wire c2_wr       = wr && paddr == `IARB_OFF_CTRL2;

   // ----------------------------------------------------------------------
   // Software registers and sticky flags; set wins over clear
   // ----------------------------------------------------------------------
   always @(posedge core_clk) begin
      if (rst) begin
         en_reg                 <= 1'b0;
         ie_reg                 <= 1'b0;
         lp_reg                 <= 1'b0;
         ackdt_reg              <= 1'b0;
         baud_reload_field_reg  <= `IARB_BAUD_RST;
         transmit_buffer_reg    <= 8'h00;
         serial_event_flag_reg  <= 1'b0;
         bus_collision_flag_reg <= 1'b0;
         wcol_reg               <= 1'b0;
      end else begin
         if (wr && paddr == `IARB_OFF_CTRL1) begin
            en_reg <= pwdata[`IARB_C1_EN];
            ie_reg <= pwdata[`IARB_C1_IE];
            lp_reg <= pwdata[`IARB_C1_LP];
         end
         if (c2_wr && !busy)
            ackdt_reg <= pwdata[`IARB_C2_ACKDT];
         if (wr && paddr == `IARB_OFF_BAUD)
            baud_reload_field_reg <= pwdata[6:0];
         if (txbuf_wr && !busy)
            transmit_buffer_reg <= pwdata[7:0];
         // Write one to clear
         if (wr && paddr == `IARB_OFF_FLAGS) begin
            if (pwdata[`IARB_FL_EVENT]) serial_event_flag_reg  <= 1'b0;
            if (pwdata[`IARB_FL_COLL])  bus_collision_flag_reg <= 1'b0;
            if (pwdata[`IARB_FL_WCOL])  wcol_reg               <= 1'b0;
         end
         if (en_reg && (done_evt || (bus_stop && (was_coll_reg || !busy))))
            serial_event_flag_reg <= 1'b1;
         if (en_reg && (coll || start_abort))
            bus_collision_flag_reg <= 1'b1;
         if (en_reg && (txbuf_wr || c2_wr) && busy)
            wcol_reg <= 1'b1;
      end
   end

endmodule

// ===== tb/iarb_chk.sv
/* Port checker for iarb_core.
   Assumes it is bound to iarb_core and the reset baud reload stays at or above 3. */
`timescale 1ns/10ps
`include "iarb_regs.vh"
module iarb_chk #(
   parameter ADDR_W = 12
) (
   input wire              core_clk,
   input wire              rst,
   input wire              psel,
   input wire              penable,
   input wire              pwrite,
   input wire [ADDR_W-1:0] paddr,
   input wire [31:0]       pwdata,
   input wire [31:0]       prdata,
   input wire              pready,
   input wire              pslverr,
   input wire              sda_in,
   input wire              sda_out,
   input wire              sda_oe,
   input wire              scl_in,
   input wire              scl_out,
   input wire              scl_oe,
   input wire              irq,
   input wire              wake
);
   // ---
   // Helpers
   // ---
   reg  [1:0] lo_cnt_reg;
   wire       wr_c1 = psel && penable && pwrite && (paddr == `IARB_OFF_CTRL1);
   wire       go_st = psel && penable && pwrite && (paddr == `IARB_OFF_CTRL2) && pwdata[0];
   wire       idle  = !sda_oe && !scl_oe;

   // Saturates: only a low that the synchroniser has surely seen counts
   always @(posedge core_clk) begin
      if (rst || sda_in)
         lo_cnt_reg <= 2'h0;
      else if (lo_cnt_reg != 2'h3)
         lo_cnt_reg <= lo_cnt_reg + 2'h1;
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   // ---
   // Assertions
   // ---
   open_drain_a: assert property (!sda_out && !scl_out)
      else $error("line driven high");
   reset_idle_a: assert property (disable iff (1'b0) rst |=> idle && !irq)
      else $error("lines or irq active after reset");
   off_idle_a: assert property (wr_c1 && !pwdata[0] |=> ##[0:2] idle)
      else $error("lines held after disable");
   wake_irq_a: assert property (wake |-> irq)
      else $error("wake without irq");
   start_low_a: assert property (go_st && lo_cnt_reg == 2'h3 && idle |=> idle [*8])
      else $error("start driven on a low line");
   start_wait_a: assert property (go_st && sda_in && scl_in && idle |=> !sda_oe [*3])
      else $error("start pulled sda too early");
   start_scl_a: assert property ($rose(sda_oe) && !scl_oe |=> !scl_oe [*2])
      else $error("scl pulled without a count");
   stop_scl_a: assert property ($rose(sda_oe) && scl_oe |=> scl_oe ##[1:40] !scl_oe)
      else $error("scl not released after sda low");
endmodule

bind iarb_core iarb_chk #(.ADDR_W(ADDR_W)) i_chk (
   .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .scl_in(scl_in),
   .scl_out(scl_out), .scl_oe(scl_oe), .irq(irq), .wake(wake));

// ===== tb/iarb_peer.sv
/* Other master on the two-wire bus, with pull-ups.
   Assumes open-drain enables from the block; mode set by the bench. */
`timescale 1ns/10ps
module iarb_peer (
   input  wire       core_clk,
   input  wire       sda_oe,
   input  wire       scl_oe,
   input  wire [1:0] mode,
   output wire       sda_in,
   output wire       scl_in,
   output reg  [8:0] rx_reg
);
   reg scl_d_reg;

   // Released lines float high through the pull-ups
   assign scl_in = !scl_oe;
   // Mode 1 holds SDA low; mode 2 sends zeros, pulling SDA while SCL is high
   assign sda_in = !(sda_oe || mode == 2'h1 || (mode == 2'h2 && scl_in));

   // Captures each bit at the SCL rise, ack slot included
   always @(posedge core_clk) begin
      scl_d_reg <= scl_in;
      if (scl_in && !scl_d_reg)
         rx_reg <= {rx_reg[7:0], sda_in};
   end
endmodule

// ===== tb/tb.sv
/* Bench for iarb_core: APB tasks and bus scenarios.
   Assumes iarb_peer as the other master and the hand-over register map. */
`timescale 1ns/10ps
`include "iarb_regs.vh"
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin err_total++; \
   $display("CHECK FAILED %s exp %0h got %0h", nm, exp, got); end end
module tb;
   localparam [11:0] C1 = `IARB_OFF_CTRL1;
   localparam [11:0] C2 = `IARB_OFF_CTRL2;
   localparam [11:0] ST = `IARB_OFF_STATUS;
   localparam [11:0] FL = `IARB_OFF_FLAGS;
   reg         core_clk, rst, psel, penable, pwrite;
   reg  [11:0] paddr;
   reg  [31:0] pwdata, d;
   reg  [1:0]  mode;
   wire [31:0] prdata;
   wire [8:0]  rx;
   wire        pready, pslverr, sda_in, sda_out, sda_oe, scl_in, scl_out, scl_oe, irq, wake;
   integer     err_total, n_compared;
   integer     cyc = 0;

   iarb_core i_dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
      .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .irq(irq), .wake(wake));
   iarb_peer i_peer (.core_clk(core_clk), .sda_oe(sda_oe), .scl_oe(scl_oe), .mode(mode),
      .sda_in(sda_in), .scl_in(scl_in), .rx_reg(rx));

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   // ---
   // Tasks
   // ---
   task results;
      begin
         if (err_total == 0 && n_compared > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask

   // Holds the request until pready is seen high; read data taken at that edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      begin
         @(posedge core_clk);
         psel <= 1'b1;
         penable <= 1'b0;
         pwrite <= w;
         paddr <= a;
         pwdata <= wd;
         @(posedge core_clk);
         penable <= 1'b1;
         @(posedge core_clk);
         while (pready !== 1'b1)
            @(posedge core_clk);
         d = prdata;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   // Gives up after 300 reads without an error; the cycle ceiling cuts longer hangs
   task poll(input logic [11:0] a, input logic [31:0] m, input logic set);
      integer i;
      begin
         for (i = 0; i < 300; i++) begin
            apb(1'b0, a, 32'h0);
            if (((d & m) != 0) == set)
               break;
         end
      end
   endtask

   task start_seq;
      begin
         apb(1'b1, C2, 32'h1);
         poll(C2, 32'h1, 1'b0);
      end
   endtask

   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total = err_total + 1;
         results;
      end
   end

   // ---
   // Scenarios
   // ---
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      mode = 2'h0;
      err_total = 0;
      n_compared = 0;
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      repeat (3) @(posedge core_clk);
      apb(1'b0, ST, 32'h0);
      `CHK("status", 32'h0, d)
      apb(1'b0, `IARB_OFF_BAUD, 32'h0);
      `CHK("baud", 32'h4, d)
      apb(1'b0, 12'h0fc, 32'h0);
      `CHK("unmapped", 32'h0, d)
      apb(1'b1, C1, 32'h3);
      // Start while another master holds SDA low
      mode <= 2'h1;
      repeat (4) @(posedge core_clk);
      apb(1'b1, C2, 32'h1);
      poll(FL, 32'h2, 1'b1);
      `CHK("irq", 1'b1, irq)
      apb(1'b0, C2, 32'h0);
      `CHK("start bit", 1'b0, d[0])
      `CHK("lines", 2'b00, {sda_oe, scl_oe})
      // Peer lets go with SCL high: a Stop on the bus
      mode <= 2'h0;
      poll(FL, 32'h1, 1'b1);
      `CHK("stop event", 1'b1, d[0])
      apb(1'b0, ST, 32'h0);
      `CHK("stop seen", 1'b1, d[4])
      apb(1'b1, FL, 32'h7);
      start_seq;
      apb(1'b0, FL, 32'h0);
      `CHK("start flags", 2'b01, d[1:0])
      apb(1'b0, ST, 32'h0);
      `CHK("start seen", 1'b1, d[3])
      apb(1'b1, FL, 32'h7);
      // Lose arbitration on the first one bit
      mode <= 2'h2;
      apb(1'b1, `IARB_OFF_TXBUF, 32'hff);
      poll(FL, 32'h2, 1'b1);
      `CHK("tx coll", 1'b1, d[1])
      apb(1'b0, ST, 32'h0);
      `CHK("buf full", 1'b0, d[0])
      `CHK("tx lines", 2'b00, {sda_oe, scl_oe})
      mode <= 2'h0;
      poll(FL, 32'h1, 1'b1);
      `CHK("coll stop", 1'b1, d[0])
      apb(1'b1, FL, 32'h7);
      // Fresh byte goes out whole; a write while busy is refused
      start_seq;
      apb(1'b1, FL, 32'h7);
      apb(1'b1, `IARB_OFF_TXBUF, 32'ha5);
      apb(1'b1, `IARB_OFF_TXBUF, 32'h00);
      poll(FL, 32'h1, 1'b1);
      `CHK("byte", 9'h14b, rx)
      `CHK("wcol", 1'b1, d[2])
      apb(1'b1, FL, 32'h7);
      // Repeated Start against a master sending zero
      mode <= 2'h2;
      apb(1'b1, C2, 32'h2);
      poll(FL, 32'h2, 1'b1);
      `CHK("rs coll", 1'b1, d[1])
      apb(1'b0, C2, 32'h0);
      `CHK("rs bit", 1'b0, d[1])
      mode <= 2'h0;
      poll(FL, 32'h1, 1'b1);
      apb(1'b1, FL, 32'h7);
      // Start ahead of the Repeated Start, Acknowledge and own Stop
      start_seq;
      apb(1'b1, FL, 32'h7);
      // Clean Repeated Start, then an Acknowledge sequence
      apb(1'b1, C2, 32'h2);
      poll(C2, 32'h2, 1'b0);
      apb(1'b0, FL, 32'h0);
      `CHK("rs flags", 2'b01, d[1:0])
      apb(1'b1, FL, 32'h7);
      apb(1'b1, C2, 32'h10);
      poll(C2, 32'h10, 1'b0);
      apb(1'b0, FL, 32'h0);
      `CHK("ack flags", 2'b01, d[1:0])
      apb(1'b1, FL, 32'h7);
      apb(1'b1, C2, 32'h4);
      poll(C2, 32'h4, 1'b0);
      apb(1'b0, ST, 32'h0);
      `CHK("own stop seen", 1'b1, d[4])
      apb(1'b0, FL, 32'h0);
      `CHK("stop flags", 2'b01, d[1:0])
      apb(1'b1, C1, 32'h7);
      @(posedge core_clk);
      `CHK("wake", 1'b1, wake)
      apb(1'b1, C1, 32'h0);
      apb(1'b0, ST, 32'h0);
      `CHK("seen cleared", 2'b00, d[4:3])
      `CHK("irq off", 1'b0, irq)
      // Reset in the middle of a Start releases the lines
      apb(1'b1, C1, 32'h1);
      apb(1'b1, C2, 32'h1);
      repeat (10) @(posedge core_clk);
      rst <= 1'b1;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      repeat (3) @(posedge core_clk);
      `CHK("rst lines", 2'b00, {sda_oe, scl_oe})
      apb(1'b0, C1, 32'h0);
      `CHK("rst en", 1'b0, d[0])
      apb(1'b0, ST, 32'h0);
      `CHK("rst seen", 2'b00, d[4:3])
      results;
   end
endmodule
